// >>> hw/dds_data_space.sv
// X and Y data spaces with two address generators and their data paths
// Operation
// - memory split into X and Y spaces
// - two generators, two paths, two concurrent reads
// - X space serves every instruction and mode
// - X space has separate read and write buses
// - X read bus carries combined and prefetch reads
// - MAC-class ops get parallel Y read path
// - modulo wrapping on both generators
// - bit reversal only on X space writes
// - all writes decode against combined X+Y range
// - X/Y boundary fixed per variant, not software
`timescale 1ns/1ps
module dds_data_space
	import dds_pkg::*;
#(
	parameter int X_WORDS = dds_pkg::DDS_X_WORDS,
	parameter int Y_WORDS = dds_pkg::DDS_Y_WORDS,
	parameter logic [15:0] BASE = dds_pkg::DDS_BASE
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire dds_pkg::dds_op_t op_in,
	input wire logic x_req_in,
	input wire logic x_we_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] x_ptr_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] x_step_in,
	input wire logic x_mod_en_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] x_mod_start_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] x_mod_end_in,
	input wire logic x_brev_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] x_brev_mod_in,
	input wire logic [dds_pkg::DDS_DATA_W-1:0] wr_data_in,
	input wire logic y_req_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] y_ptr_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] y_step_in,
	input wire logic y_mod_en_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] y_mod_start_in,
	input wire logic [dds_pkg::DDS_ADDR_W-1:0] y_mod_end_in,
	output logic [dds_pkg::DDS_DATA_W-1:0] x_rd_data_out,
	output logic [dds_pkg::DDS_DATA_W-1:0] y_rd_data_out,
	output logic x_valid_out,
	output logic y_valid_out,
	output logic x_fault_out,
	output logic y_fault_out,
	output logic [dds_pkg::DDS_ADDR_W-1:0] x_ptr_next_out,
	output logic [dds_pkg::DDS_ADDR_W-1:0] y_ptr_next_out
);
	import dds_pkg::*;

	// ----------------------------------------------------------------
	// fixed map: the boundary is elaborated, never written
	// ----------------------------------------------------------------
	localparam int XI_W = $clog2(X_WORDS);
	localparam int YI_W = $clog2(Y_WORDS);
	localparam logic [15:0] BOUND = 16'(BASE + 2 * X_WORDS);
	localparam logic [15:0] TOP = 16'(BOUND + 2 * Y_WORDS);

	logic [DDS_DATA_W-1:0] x_mem [X_WORDS];
	logic [DDS_DATA_W-1:0] y_mem [Y_WORDS];

	wire logic [DDS_ADDR_W-1:0] x_ea;
	wire logic [DDS_ADDR_W-1:0] y_ea;
	wire logic [DDS_ADDR_W-1:0] x_next;
	wire logic [DDS_ADDR_W-1:0] y_next;

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	wire logic mac_class;
	wire logic x_rd;
	wire logic x_wr;
	wire logic y_rd;
	wire logic x_brev_ok;

	// the eight MAC-class operations own the Y read path
	assign mac_class = (op_in != DDS_OP_MCU);
	assign x_rd = x_req_in && !x_we_in;
	assign x_wr = x_req_in && x_we_in;
	assign y_rd = y_req_in && mac_class;
	// bit reversal is dropped on X reads; Y never gets it
	assign x_brev_ok = x_brev_in && x_wr;

	// ----------------------------------------------------------------
	// two independent address generators
	// ----------------------------------------------------------------
	dds_addr_gen #(.AW(DDS_ADDR_W)) u_x_gen (
		.ptr_in(x_ptr_in),
		.step_in(x_step_in),
		.mod_en_in(x_mod_en_in),
		.mod_start_in(x_mod_start_in),
		.mod_end_in(x_mod_end_in),
		.brev_en_in(x_brev_ok),
		.brev_mod_in(x_brev_mod_in),
		.ea_out(x_ea),
		.next_ptr_out(x_next)
	);

	dds_addr_gen #(.AW(DDS_ADDR_W)) u_y_gen (
		.ptr_in(y_ptr_in),
		.step_in(y_step_in),
		.mod_en_in(y_mod_en_in),
		.mod_start_in(y_mod_start_in),
		.mod_end_in(y_mod_end_in),
		.brev_en_in(1'b0),
		.brev_mod_in(x_brev_mod_in),
		.ea_out(y_ea),
		.next_ptr_out(y_next)
	);

	// ----------------------------------------------------------------
	// space decode on the combined linear range
	// ----------------------------------------------------------------
	wire logic x_in_x;
	wire logic x_in_y;
	wire logic y_in_y;
	wire logic [DDS_ADDR_W-1:0] x_off_x;
	wire logic [DDS_ADDR_W-1:0] x_off_y;
	wire logic [DDS_ADDR_W-1:0] y_off_y;
	wire logic [XI_W-1:0] x_idx;
	wire logic [YI_W-1:0] xy_idx;
	wire logic [YI_W-1:0] y_idx;

	// the X generator sees one linear range covering both spaces
	assign x_in_x = (x_ea >= BASE) && (x_ea < BOUND);
	assign x_in_y = (x_ea >= BOUND) && (x_ea < TOP);
	assign y_in_y = (y_ea >= BOUND) && (y_ea < TOP);
	assign x_off_x = DDS_ADDR_W'(x_ea - BASE);
	assign x_off_y = DDS_ADDR_W'(x_ea - BOUND);
	assign y_off_y = DDS_ADDR_W'(y_ea - BOUND);
	assign x_idx = x_off_x[XI_W:1];
	assign xy_idx = x_off_y[YI_W:1];
	assign y_idx = y_off_y[YI_W:1];

	// ----------------------------------------------------------------
	// read selection
	// ----------------------------------------------------------------
	wire logic [DDS_DATA_W-1:0] next_x_rd_data;
	wire logic [DDS_DATA_W-1:0] next_y_rd_data;
	wire logic next_y_fault;

	// the X bus returns Y words too when the address lies between the boundary and the top of Y space
	assign next_x_rd_data = x_in_x ? x_mem[x_idx] : (x_in_y ? y_mem[xy_idx] : DDS_DATA_RST);
	// a Y operand outside Y space reads as zero and is flagged
	assign next_y_rd_data = y_in_y ? y_mem[y_idx] : DDS_DATA_RST;
	assign next_y_fault = y_rd && !y_in_y;

	// ----------------------------------------------------------------
	// write path: combined decode, no separate Y write port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (x_wr && x_in_x) begin
			x_mem[x_idx] <= wr_data_in;
		end
	end

	// a DSP write into Y space still arrives on the X address
	always_ff @(posedge ref_clk_in) begin
		if (x_wr && x_in_y) begin
			y_mem[xy_idx] <= wr_data_in;
		end
	end

	// ----------------------------------------------------------------
	// registered read answers, both in the cycle after the request
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			x_rd_data_out <= DDS_DATA_RST;
			x_valid_out <= 1'b0;
			x_fault_out <= 1'b0;
		end else begin
			x_valid_out <= x_rd;
			x_fault_out <= x_req_in && !x_in_x && !x_in_y;
			if (x_rd) begin
				x_rd_data_out <= next_x_rd_data;
			end
		end
	end

	// Y answers in parallel; nothing here can hold the X side back
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			y_rd_data_out <= DDS_DATA_RST;
			y_valid_out <= 1'b0;
			y_fault_out <= 1'b0;
		end else begin
			y_valid_out <= y_rd;
			y_fault_out <= next_y_fault;
			if (y_rd) begin
				y_rd_data_out <= next_y_rd_data;
			end
		end
	end

	// updated pointers go back to the working registers
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			x_ptr_next_out <= DDS_PTR_RST;
			y_ptr_next_out <= DDS_PTR_RST;
		end else begin
			if (x_req_in) begin
				x_ptr_next_out <= x_next;
			end
			if (y_rd) begin
				y_ptr_next_out <= y_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking dds_cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	wire logic [DDS_ADDR_W-1:0] x_plain_next;
	wire logic [DDS_ADDR_W-1:0] y_plain_next;
	assign x_plain_next = DDS_ADDR_W'(x_ptr_in + x_step_in);
	assign y_plain_next = DDS_ADDR_W'(y_ptr_in + y_step_in);

	AST_X_READ_ANSWER: assert property (
		x_rd |-> ##1 x_valid_out)
		else $error("x read not answered next cycle");

	AST_DUAL_TOGETHER: assert property (
		(x_rd && y_rd && x_in_x && y_in_y) |-> ##1 (x_valid_out && y_valid_out && !y_fault_out))
		else $error("dual read operands not returned together");

	AST_Y_NEVER_REVERSED: assert property (
		(y_rd && !y_mod_en_in) |=> (y_ptr_next_out == $past(y_plain_next)))
		else $error("y pointer not plainly updated");

	AST_X_READ_NOT_REVERSED: assert property (
		(x_rd && x_brev_in && !x_mod_en_in) |=> (x_ptr_next_out == $past(x_plain_next)))
		else $error("x read used bit reversal");

	AST_WRITE_COMBINED: assert property (
		(x_wr && x_in_y) ##1 (x_rd && x_ptr_in == $past(x_ptr_in))
		|=> (x_rd_data_out == $past(wr_data_in, 2)))
		else $error("write into y space not seen on x read bus");

	AST_Y_OUTSIDE_FAULT: assert property (
		(y_rd && !y_in_y) |=> (y_fault_out && y_rd_data_out == DDS_DATA_RST))
		else $error("y read outside y space not flagged");

	AST_Y_ONLY_MAC: assert property (
		(y_req_in && !mac_class) |=> !y_valid_out)
		else $error("y path used by non mac-class op");

	AST_MOD_WRAP: assert property (
		(x_req_in && x_mod_en_in && !x_brev_ok && !x_step_in[15] && x_plain_next > x_mod_end_in
		&& x_plain_next < 16'(x_mod_end_in + 16'h0002) && x_mod_end_in >= x_mod_start_in)
		|=> (x_ptr_next_out <= x_mod_end_in && x_ptr_next_out >= x_mod_start_in))
		else $error("modulo wrap left the buffer");

	AST_Y_READS_Y_WORD: assert property (
		(y_rd && y_in_y && x_wr && x_in_y && x_ea == y_ea) |=> (y_rd_data_out != $past(wr_data_in))
		|| ($past(next_y_rd_data) == $past(wr_data_in)))
		else $error("y read took the write bus instead of its own path");
endmodule : dds_data_space

// >>> hw/dds_pkg.sv
// shared constants and types of the dual data space access block
package dds_pkg;
	// ----------------------------------------------------------------
	// widths and map
	// ----------------------------------------------------------------
	localparam int DDS_ADDR_W = 16;
	localparam int DDS_DATA_W = 16;
	localparam int DDS_X_WORDS = 2048;
	localparam int DDS_Y_WORDS = 2048;
	localparam logic [15:0] DDS_BASE = 16'h0000;
	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [15:0] DDS_PTR_RST = 16'h0000;
	localparam logic [15:0] DDS_DATA_RST = 16'h0000;
	// read data appears this many cycles after the request edge
	localparam int DDS_RD_LAT = 1;
	// ----------------------------------------------------------------
	// instruction classes seen by the data spaces
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		DDS_OP_MCU,
		DDS_OP_CLEAR,
		DDS_OP_DISTANCE,
		DDS_OP_DISTANCE_ACCUMULATE,
		DDS_OP_MAC,
		DDS_OP_MOVE_STORE_ACCUMULATOR,
		DDS_OP_MULTIPLY,
		DDS_OP_NEGATED_MULTIPLY,
		DDS_OP_MULTIPLY_SUBTRACT
	} dds_op_t;
endpackage : dds_pkg

// >>> hw/dds_addr_gen.sv
// one address generator: effective address plus modulo or bit-reversed update
`timescale 1ns/1ps
module dds_addr_gen #(
	parameter int AW = 16
) (
	input wire logic [AW-1:0] ptr_in,
	input wire logic [AW-1:0] step_in,
	input wire logic mod_en_in,
	input wire logic [AW-1:0] mod_start_in,
	input wire logic [AW-1:0] mod_end_in,
	input wire logic brev_en_in,
	input wire logic [AW-1:0] brev_mod_in,
	output logic [AW-1:0] ea_out,
	output logic [AW-1:0] next_ptr_out
);
	// ----------------------------------------------------------------
	// address arithmetic
	// ----------------------------------------------------------------
	function automatic logic [AW-1:0] rev(input logic [AW-1:0] v);
		for (int i = 0; i < AW; i++) begin
			rev[i] = v[AW-1-i];
		end
	endfunction : rev

	logic [AW-1:0] sum;
	logic [AW-1:0] span;
	logic [AW-1:0] wrapped;
	logic [AW-1:0] rev_next;
	logic going_down;

	// word aligned access, the low byte bit is ignored
	assign ea_out = {ptr_in[AW-1:1], 1'b0};
	assign sum = AW'(ptr_in + step_in);
	assign span = AW'(mod_end_in - mod_start_in + 1'b1);
	assign going_down = step_in[AW-1];
	// wrap by one buffer length; steps larger than the buffer are not folded
	assign wrapped = (!going_down && sum > mod_end_in) ? AW'(sum - span) :
		(going_down && sum < mod_start_in) ? AW'(sum + span) : sum;
	// reverse-carry add walks the buffer in bit-reversed order
	assign rev_next = rev(AW'(rev(ptr_in) + rev(brev_mod_in)));
	// bit reversal takes priority over modulo when both are asked for
	assign next_ptr_out = brev_en_in ? rev_next : (mod_en_in ? wrapped : sum);
endmodule : dds_addr_gen

// >>> testbench/dds_core_model.sv
// core-side model that issues X and Y data space requests
`timescale 1ns/1ps
module dds_core_model
	import dds_pkg::*;
(
	input wire logic ref_clk_in,
	output dds_pkg::dds_op_t op_out,
	output logic x_req_out,
	output logic x_we_out,
	output logic [15:0] x_ptr_out,
	output logic [15:0] x_step_out,
	output logic x_mod_en_out,
	output logic x_brev_out,
	output logic [15:0] wr_data_out,
	output logic y_req_out,
	output logic [15:0] y_ptr_out,
	output logic [15:0] y_step_out,
	output logic y_mod_en_out
);
	// steps stay at one word; only pointers, data and modes vary
	initial begin
		op_out = DDS_OP_MCU;
		{x_req_out, x_we_out, x_mod_en_out, x_brev_out, y_req_out, y_mod_en_out} = 6'h00;
		{x_ptr_out, wr_data_out, y_ptr_out} = 48'h0;
		x_step_out = 16'h0002;
		y_step_out = 16'h0002;
	end
	// a request changes at the falling edge, away from the taking edge
	task automatic req(input dds_op_t op, input logic xr, xw, input logic [15:0] xp, wd,
		input logic yr, input logic [15:0] yp, input logic xm, ym, xb);
		@(negedge ref_clk_in);
		op_out = op;
		{x_req_out, x_we_out, x_ptr_out, wr_data_out} = {xr, xw, xp, wd};
		{y_req_out, y_ptr_out, x_mod_en_out, y_mod_en_out, x_brev_out} = {yr, yp, xm, ym, xb};
	endtask : req
	// released buses invert so a stale word is never mistaken for live data
	task automatic idle();
		@(negedge ref_clk_in);
		{x_req_out, y_req_out} = 2'b00;
		wr_data_out = ~wr_data_out;
		x_ptr_out = ~x_ptr_out;
		y_ptr_out = ~y_ptr_out;
	endtask : idle
endmodule : dds_core_model

// >>> testbench/dual_data_space_access_tb.sv
// self-checking bench of the dual data space access block
`timescale 1ns/1ps
module dual_data_space_access_tb;
	import dds_pkg::*;
	typedef struct packed {
		dds_op_t op;
		logic xw;
		logic [15:0] xp, wd;
		logic yr;
		logic [15:0] yp, exd, eyd;
		logic [1:0] fl;
	} dds_row_t;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	dds_op_t op;
	logic x_req, x_we, x_mod_en, x_brev, y_req, y_mod_en;
	logic [15:0] x_ptr, x_step, wr_data, y_ptr, y_step;
	logic [15:0] x_rd_data_out, y_rd_data_out, x_ptr_next_out, y_ptr_next_out;
	logic x_valid_out, y_valid_out, x_fault_out, y_fault_out;
	int n_mismatch = 0;
	int samples_checked = 0;
	int o;
	dds_row_t r;
	logic [15:0] eyp = 16'h0000;
	// boundary sits at 16'h1000; rows use one word each side of it
	dds_row_t rows [5] = '{
		'{DDS_OP_MCU, 1, 16'h0004, 16'h1111, 0, 16'h0000, 16'h0000, 16'h0000, 2'b00},
		'{DDS_OP_MAC, 1, 16'h1006, 16'h2222, 0, 16'h0000, 16'h0000, 16'h0000, 2'b00},
		'{DDS_OP_MAC, 0, 16'h0004, 16'h0000, 1, 16'h1006, 16'h1111, 16'h2222, 2'b11},
		'{DDS_OP_MCU, 0, 16'h1006, 16'h0000, 0, 16'h0000, 16'h2222, 16'h2222, 2'b10},
		'{DDS_OP_MCU, 0, 16'h0004, 16'h0000, 1, 16'h1006, 16'h1111, 16'h2222, 2'b10}};
	always #12.5 ref_clk_in = ~ref_clk_in;
	// ----------------------------------------------------------------
	// instances; modulo windows and reverse modifier are fixed wiring
	// ----------------------------------------------------------------
	dds_core_model dds_core_model_i (.ref_clk_in(ref_clk_in), .op_out(op), .x_req_out(x_req),
		.x_we_out(x_we), .x_ptr_out(x_ptr), .x_step_out(x_step), .x_mod_en_out(x_mod_en),
		.x_brev_out(x_brev), .wr_data_out(wr_data), .y_req_out(y_req), .y_ptr_out(y_ptr),
		.y_step_out(y_step), .y_mod_en_out(y_mod_en));
	dds_data_space dds_data_space_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.op_in(op), .x_req_in(x_req), .x_we_in(x_we), .x_ptr_in(x_ptr), .x_step_in(x_step),
		.x_mod_en_in(x_mod_en), .x_mod_start_in(16'h0008), .x_mod_end_in(16'h000f),
		.x_brev_in(x_brev), .x_brev_mod_in(16'h0010), .wr_data_in(wr_data), .y_req_in(y_req),
		.y_ptr_in(y_ptr), .y_step_in(y_step), .y_mod_en_in(y_mod_en),
		.y_mod_start_in(16'h1010), .y_mod_end_in(16'h1017), .x_rd_data_out(x_rd_data_out),
		.y_rd_data_out(y_rd_data_out), .x_valid_out(x_valid_out), .y_valid_out(y_valid_out),
		.x_fault_out(x_fault_out), .y_fault_out(y_fault_out),
		.x_ptr_next_out(x_ptr_next_out), .y_ptr_next_out(y_ptr_next_out));
	// ----------------------------------------------------------------
	// compare and report
	// ----------------------------------------------------------------
	task automatic c16(input string n, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : c16
	task automatic cf(input string n, input logic [3:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask : cf
	// flags are valid x, valid y, fault x, fault y
	task automatic look(input logic [15:0] xd, yd, input logic [3:0] fl, input logic [15:0] xp, yp);
		c16("x_rd_data", xd, x_rd_data_out);
		c16("y_rd_data", yd, y_rd_data_out);
		cf("flags", fl, {x_valid_out, y_valid_out, x_fault_out, y_fault_out});
		c16("x_ptr_next", xp, x_ptr_next_out);
		c16("y_ptr_next", yp, y_ptr_next_out);
	endtask : look
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// watchdog: the sequence needs well under 200 cycles
	initial begin
		#(400 * 25);
		n_mismatch++;
		tally_and_finish();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge ref_clk_in);
		// look away from the edge so the reset values are settled
		@(negedge ref_clk_in);
		look(16'h0, 16'h0, 4'h0, 16'h0, 16'h0);
		sys_rst_in = 1'b0;
		// ordinary cases; a Y request under an ordinary op must be ignored
		foreach (rows[i]) begin
			r = rows[i];
			dds_core_model_i.req(r.op, 1, r.xw, r.xp, r.wd, r.yr, r.yp, 0, 0, 0);
			dds_core_model_i.idle();
			if (r.yr && r.op != DDS_OP_MCU)
				eyp = r.yp + 16'h0002;
			look(r.exd, r.eyd, {r.fl, 2'b00}, r.xp + 16'h0002, eyp);
		end
		$display("table rows done");
		// every multiply-accumulate class op opens the Y path
		for (o = 1; o <= 8; o++) begin
			dds_core_model_i.req(dds_op_t'(o), 1, 0, 16'h0004, 0, 1, 16'h1006, 0, 0, 0);
			dds_core_model_i.idle();
			look(16'h1111, 16'h2222, 4'b1100, 16'h0006, 16'h1008);
		end
		// write then read of the same word on the very next edge
		dds_core_model_i.req(DDS_OP_MCU, 1, 1, 16'h0008, 16'h3333, 0, 0, 0, 0, 0);
		dds_core_model_i.req(DDS_OP_MCU, 1, 0, 16'h0008, 16'h0000, 0, 0, 0, 0, 0);
		dds_core_model_i.idle();
		look(16'h3333, 16'h2222, 4'b1000, 16'h000a, 16'h1008);
		// X beyond the whole range and Y below the boundary both fault
		dds_core_model_i.req(DDS_OP_MULTIPLY, 1, 0, 16'h2000, 0, 1, 16'h0004, 0, 0, 0);
		dds_core_model_i.idle();
		cf("faults", 4'b0011, {2'b00, x_fault_out, y_fault_out});
		c16("x_fault_data", 16'h0000, x_rd_data_out);
		c16("y_fault_data", 16'h0000, y_rd_data_out);
		// modulo wrap at the last word of each buffer
		dds_core_model_i.req(DDS_OP_MAC, 1, 0, 16'h000e, 0, 1, 16'h1016, 1, 1, 0);
		dds_core_model_i.idle();
		c16("x_mod_ptr", 16'h0008, x_ptr_next_out);
		c16("y_mod_ptr", 16'h1010, y_ptr_next_out);
		// reversed update on an X write only, never on an X read
		dds_core_model_i.req(DDS_OP_MCU, 1, 1, 16'h0000, 16'h4444, 0, 0, 0, 0, 1);
		dds_core_model_i.idle();
		c16("x_brev_wr_ptr", 16'h0010, x_ptr_next_out);
		dds_core_model_i.req(DDS_OP_MCU, 1, 0, 16'h0000, 0, 0, 0, 0, 0, 1);
		dds_core_model_i.idle();
		c16("x_brev_rd_ptr", 16'h0002, x_ptr_next_out);
		c16("x_brev_rd_data", 16'h4444, x_rd_data_out);
		// X write into Y space beside a Y read of that word, then an X read of it
		dds_core_model_i.req(DDS_OP_MAC, 1, 1, 16'h1006, 16'h5555, 1, 16'h1006, 0, 0, 0);
		dds_core_model_i.req(DDS_OP_MCU, 1, 0, 16'h1006, 16'h0000, 0, 0, 0, 0, 0);
		dds_core_model_i.idle();
		look(16'h5555, 16'h2222, 4'b1000, 16'h1008, 16'h1008);
		$display("awkward cases done");
		// second reset in mid-run clears every output at once
		sys_rst_in = 1'b1;
		#1;
		look(16'h0, 16'h0, 4'h0, 16'h0, 16'h0);
		@(negedge ref_clk_in);
		sys_rst_in = 1'b0;
		// no request at the first edge after release, so outputs stay cleared
		@(negedge ref_clk_in);
		look(16'h0, 16'h0, 4'h0, 16'h0, 16'h0);
		// data words survive reset; only the registered outputs are cleared
		dds_core_model_i.req(DDS_OP_MCU, 1, 0, 16'h0000, 16'h0000, 0, 0, 0, 0, 0);
		dds_core_model_i.idle();
		look(16'h4444, 16'h0, 4'b1000, 16'h0002, 16'h0);
		$display("reset test done");
		tally_and_finish();
	end
endmodule : dual_data_space_access_tb
